// File: include/spimsr_pkg.sv
// constants, field positions and state types of the serial master/slave unit
//
// Functional notes
// - control: function enable b0, protocol select b24, master select b30.
// - control: mode fault detect enable b14, error irq b16, rx-full irq b17.
// - control: tx-empty irq enable at b20 gates the tx-empty request.
// - standard protocol: select polarity 0 is active low, 1 active high.
// - frame protocol: polarity meaning inverted, 0 active high, 1 active low.
// - status: overrun b8, idle b9, mode fault b10.
// - status: parity b11, underrun b12, tx-empty b13.
// - status: comm end b14, rx-full b15, plus separate rx-data-ready flag.
// - data control b3 picks received or transmit data on data read.
// - master negate delay is code plus one serial clocks, 1 to 8.
// - frame-protocol slave negate delay counts peripheral clocks, code plus one.
// - next-access delay is code plus one serial clocks, counting only those that end after its first five clocks.
// - command bits 26..24 choose the select line asserted for that command.
// - next-access enable 0 gives one serial clock, the first one that ends after five clocks.
// - negate enable 0 gives one serial clock (master) or one clock (frame-protocol slave); a standard-protocol slave has no negate delay.
// - clock delay enable 0: one serial clock standard, zero frame protocol.
// - clock delay enable 1 uses the clock delay register value.
// - slave mode: select 0 is input, lines 1 to 3 left undriven.
// - master runs up to eight commands in turn, then loops back.
`default_nettype none
package spimsr_pkg;
	// ************************************************
	// register word addresses
	// ************************************************
	localparam logic [4:0] ADDR_CONTROL = 5'h00;
	localparam logic [4:0] ADDR_STATUS = 5'h01;
	localparam logic [4:0] ADDR_DATA_CONTROL = 5'h02;
	localparam logic [4:0] ADDR_POLARITY = 5'h03;
	localparam logic [4:0] ADDR_NEGATE_DELAY = 5'h04;
	localparam logic [4:0] ADDR_NEXT_DELAY = 5'h05;
	localparam logic [4:0] ADDR_CLOCK_DELAY = 5'h06;
	localparam logic [4:0] ADDR_DATA = 5'h07;
	localparam logic [4:0] ADDR_SEQ_LAST = 5'h08;
	localparam logic [4:0] ADDR_CMD_BASE = 5'h10;
	// ************************************************
	// field positions
	// ************************************************
	localparam int unsigned CTL_ENABLE = 0;
	localparam int unsigned CTL_MODE_FAULT_FLAG_EN = 14;
	localparam int unsigned CTL_ERR_IE = 16;
	localparam int unsigned CTL_RXF_IE = 17;
	localparam int unsigned CTL_TXE_IE = 20;
	localparam int unsigned CTL_PROTOCOL = 24;
	localparam int unsigned CTL_MASTER = 30;
	localparam int unsigned STS_RX_READY = 0;
	localparam int unsigned STS_OVERRUN = 8;
	localparam int unsigned STS_IDLE = 9;
	localparam int unsigned STS_MODE_FAULT_FLAG = 10;
	localparam int unsigned STS_PARITY = 11;
	localparam int unsigned STS_UNDERRUN = 12;
	localparam int unsigned STS_TXE = 13;
	localparam int unsigned STS_COMM_END = 14;
	localparam int unsigned STS_RXF = 15;
	localparam int unsigned DCR_READBACK = 3;
	localparam int unsigned CMD_CPHA = 0;
	localparam int unsigned CMD_CPOL = 1;
	localparam int unsigned CMD_RATE_LSB = 4;
	localparam int unsigned CMD_LSB_FIRST = 12;
	localparam int unsigned CMD_CLKD_EN = 13;
	localparam int unsigned CMD_NEGD_EN = 14;
	localparam int unsigned CMD_NEXTD_EN = 15;
	localparam int unsigned CMD_LEN_LSB = 16;
	localparam int unsigned CMD_SEL_LSB = 24;
	// ************************************************
	// reset values and timing counts
	// ************************************************
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
	localparam logic [31:0] CMD_RESET = 32'h0007_0000;
	localparam logic [3:0] POLARITY_RESET = 4'h0;
	localparam logic [2:0] DELAY_RESET = 3'h0;
	localparam logic [2:0] NEXT_EXTRA_PCLK = 3'h5;
	localparam logic [3:0] ONE_UNIT = 4'h1;
	typedef enum logic [2:0] {SM_IDLE, SM_LEAD, SM_SHIFT, SM_LAG, SM_NEXT} spimsr_state_type;
endpackage
`default_nettype wire

// File: core/spimsr_core.sv
// serial master/slave unit: register port, sequencer, shifter and pins
//
// The plain strobed port and the address map were decided locally.
`default_nettype none
module spimsr_core import spimsr_pkg::*; #(
	parameter int unsigned NUM_CMDS = 8
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [4:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic sclk_i,
	output logic sclk_o,
	output logic sclk_oe_o,
	input wire logic mosi_i,
	output logic mosi_o,
	output logic mosi_oe_o,
	input wire logic miso_i,
	output logic miso_o,
	output logic miso_oe_o,
	input wire logic [3:0] sel_i,
	output logic [3:0] sel_o,
	output logic [3:0] sel_oe_o,
	output logic irq_rx_o,
	output logic irq_tx_o,
	output logic irq_err_o
);
	// ************************************************
	// helpers
	// ************************************************
	function automatic logic [3:0] plus1(input logic [2:0] c);
		return {1'b0, c} + ONE_UNIT;
	endfunction

	logic [31:0] ctl_q, tx_buf_q, rx_buf_q, cur_q, tx_sh_q, rx_sh_q, rdata_q;
	logic [31:0] cmd_q [NUM_CMDS];
	logic [3:0] pol_q, s1_q, s2_q, s3_q, stab_q, sel_q, sel_oe_q;
	logic [2:0] negd_q, nextd_q, ckd_q, seq_last_q, idx_q, pcnt_q;
	logic [3:0] cnt_q;
	logic [7:0] div_q;
	logic [5:0] edge_q;
	logic readback_q, phase_q, sclk_q, sclk_prev_q;
	logic txe_q, rxf_q, ovr_q, mode_fault_flag_q, udr_q, cend_q;
	logic sclk_oe_q, mosi_q, mosi_oe_q, miso_q, miso_oe_q, irq_rx_q, irq_tx_q, irq_err_q;
	spimsr_state_type st_q;

	logic master_en, slave_en, ssp, sel_in_act, half_tick, bit_tick, cnt_tick;
	logic edge_ev, sample_ev, shift_ev, last_edge, rx_bit, out_bit, start, start_s;
	logic data_rd, busy_sel;
	logic [4:0] len_m1;
	logic [31:0] cmdw, rx_nx;
	logic [3:0] lead_w, lag_w, next_w;

	// ************************************************
	// input synchronisers
	// ************************************************
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q <= 4'h0;
			s2_q <= 4'h0;
			s3_q <= 4'h0;
			stab_q <= 4'h0;
			sclk_prev_q <= 1'b0;
		end else begin
			s1_q <= {sel_i[0], mosi_i, miso_i, sclk_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int k = 0; k < 4; k++) begin
				if (s2_q[k] == s3_q[k]) begin
					stab_q[k] <= s3_q[k];
				end
			end
			sclk_prev_q <= stab_q[0];
		end
	end

	// ************************************************
	// decode of mode, command and delays
	// ************************************************
	always_comb begin
		master_en = ctl_q[CTL_ENABLE] & ctl_q[CTL_MASTER];
		slave_en = ctl_q[CTL_ENABLE] & ~ctl_q[CTL_MASTER];
		ssp = ctl_q[CTL_PROTOCOL];
		sel_in_act = stab_q[3] == (pol_q[0] ^ ssp);
		len_m1 = cur_q[CMD_LEN_LSB +: 5];
		half_tick = div_q == cur_q[CMD_RATE_LSB +: 8];
		bit_tick = half_tick & phase_q;
		cnt_tick = ctl_q[CTL_MASTER] ? bit_tick : 1'b1;
		cmdw = ctl_q[CTL_MASTER] ? cmd_q[idx_q] : cmd_q[0];
		start_s = st_q == SM_IDLE && slave_en && sel_in_act;
		start = (st_q == SM_IDLE && master_en && !txe_q) || start_s;
		if (cmdw[CMD_CLKD_EN]) begin
			lead_w = plus1(ckd_q);
		end else begin
			lead_w = ssp ? 4'h0 : ONE_UNIT;
		end
		if (cur_q[CMD_NEGD_EN]) begin
			lag_w = plus1(negd_q);
		end else begin
			lag_w = ONE_UNIT;
		end
		if (!ctl_q[CTL_MASTER] && !ssp) begin
			lag_w = 4'h0;
		end
		next_w = cur_q[CMD_NEXTD_EN] ? plus1(nextd_q) : ONE_UNIT;
		if (ctl_q[CTL_MASTER]) begin
			edge_ev = st_q == SM_SHIFT && half_tick;
			rx_bit = stab_q[1];
		end else begin
			edge_ev = st_q == SM_SHIFT && stab_q[0] != sclk_prev_q;
			rx_bit = stab_q[2];
		end
		sample_ev = edge_ev && edge_q[0] == cur_q[CMD_CPHA];
		shift_ev = edge_ev && edge_q[0] != cur_q[CMD_CPHA] && edge_q != 6'h00;
		last_edge = edge_ev && edge_q == {len_m1, 1'b1};
		out_bit = cur_q[CMD_LSB_FIRST] ? tx_sh_q[0] : tx_sh_q[len_m1];
		rx_nx = rx_sh_q;
		if (sample_ev) begin
			rx_nx = cur_q[CMD_LSB_FIRST] ? {rx_bit, rx_sh_q[31:1]} : {rx_sh_q[30:0], rx_bit};
		end
		data_rd = rd_i && addr_i == ADDR_DATA && !readback_q;
		busy_sel = st_q == SM_LEAD || st_q == SM_SHIFT || st_q == SM_LAG;
	end

	// ************************************************
	// sequencer and serial clock timing
	// ************************************************
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= SM_IDLE;
			cur_q <= CMD_RESET;
			cnt_q <= 4'h0;
			pcnt_q <= 3'h0;
			div_q <= 8'h00;
			phase_q <= 1'b0;
			sclk_q <= 1'b0;
			edge_q <= 6'h00;
			idx_q <= 3'h0;
		end else if (!ctl_q[CTL_ENABLE]) begin
			st_q <= SM_IDLE;
			idx_q <= 3'h0;
			sclk_q <= cur_q[CMD_CPOL];
		end else begin
			if (st_q != SM_IDLE) begin
				div_q <= half_tick ? 8'h00 : div_q + 8'h01;
				if (half_tick) begin
					phase_q <= ~phase_q;
				end
			end
			unique case (st_q)
				SM_IDLE: begin
					if (start) begin
						cur_q <= cmdw;
						edge_q <= 6'h00;
						div_q <= 8'h00;
						phase_q <= 1'b0;
						sclk_q <= cmdw[CMD_CPOL];
						cnt_q <= lead_w;
						st_q <= (ctl_q[CTL_MASTER] && lead_w != 4'h0) ? SM_LEAD : SM_SHIFT;
					end
				end
				SM_LEAD: begin
					if (bit_tick) begin
						cnt_q <= cnt_q - 4'h1;
						if (cnt_q == 4'h1) begin
							st_q <= SM_SHIFT;
						end
					end
				end
				SM_SHIFT: begin
					if (ctl_q[CTL_MASTER] && half_tick) begin
						sclk_q <= ~sclk_q;
					end
					if (edge_ev) begin
						edge_q <= edge_q + 6'h01;
					end
					if (!ctl_q[CTL_MASTER] && !sel_in_act) begin
						st_q <= SM_IDLE;
					end else if (last_edge) begin
						div_q <= 8'h00;
						phase_q <= 1'b0;
						cnt_q <= lag_w;
						st_q <= lag_w == 4'h0 ? SM_IDLE : SM_LAG;
					end
				end
				SM_LAG: begin
					if (cnt_tick) begin
						cnt_q <= cnt_q - 4'h1;
						if (cnt_q == 4'h1) begin
							cnt_q <= next_w;
							pcnt_q <= NEXT_EXTRA_PCLK;
							st_q <= ctl_q[CTL_MASTER] ? SM_NEXT : SM_IDLE;
						end
					end
				end
				SM_NEXT: begin
					if (pcnt_q != 3'h0) begin
						pcnt_q <= pcnt_q - 3'h1;
					end else if (bit_tick) begin
						cnt_q <= cnt_q - 4'h1;
						if (cnt_q == 4'h1) begin
							st_q <= SM_IDLE;
							idx_q <= idx_q == seq_last_q ? 3'h0 : idx_q + 3'h1;
						end
					end
				end
			endcase
		end
	end

	// ************************************************
	// shifter
	// ************************************************
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_sh_q <= 32'h0000_0000;
			rx_sh_q <= 32'h0000_0000;
		end else if (start) begin
			tx_sh_q <= tx_buf_q;
			rx_sh_q <= 32'h0000_0000;
		end else begin
			if (shift_ev) begin
				tx_sh_q <= cur_q[CMD_LSB_FIRST] ? tx_sh_q >> 1 : tx_sh_q << 1;
			end
			rx_sh_q <= rx_nx;
		end
	end

	// ************************************************
	// registers and status
	// ************************************************
	// a data write wins over the load that empties the buffer, so no word is lost
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctl_q <= CONTROL_RESET;
			pol_q <= POLARITY_RESET;
			negd_q <= DELAY_RESET;
			nextd_q <= DELAY_RESET;
			ckd_q <= DELAY_RESET;
			seq_last_q <= 3'h7;
			readback_q <= 1'b0;
			tx_buf_q <= 32'h0000_0000;
			rx_buf_q <= 32'h0000_0000;
			for (int i = 0; i < NUM_CMDS; i++) begin
				cmd_q[i] <= CMD_RESET;
			end
			txe_q <= 1'b1;
			rxf_q <= 1'b0;
			ovr_q <= 1'b0;
			mode_fault_flag_q <= 1'b0;
			udr_q <= 1'b0;
			cend_q <= 1'b0;
		end else begin
			if (wr_i) begin
				unique case (addr_i)
					ADDR_CONTROL: ctl_q <= wdata_i;
					ADDR_DATA_CONTROL: readback_q <= wdata_i[DCR_READBACK];
					ADDR_POLARITY: pol_q <= wdata_i[3:0];
					ADDR_NEGATE_DELAY: negd_q <= wdata_i[2:0];
					ADDR_NEXT_DELAY: nextd_q <= wdata_i[2:0];
					ADDR_CLOCK_DELAY: ckd_q <= wdata_i[2:0];
					ADDR_SEQ_LAST: seq_last_q <= wdata_i[2:0];
					ADDR_STATUS: begin
						ovr_q <= ovr_q & wdata_i[STS_OVERRUN];
						mode_fault_flag_q <= mode_fault_flag_q & wdata_i[STS_MODE_FAULT_FLAG];
						udr_q <= udr_q & wdata_i[STS_UNDERRUN];
						cend_q <= cend_q & wdata_i[STS_COMM_END];
					end
					default: begin
						if (addr_i[4] && addr_i[3:0] < 4'(NUM_CMDS)) begin
							cmd_q[addr_i[2:0]] <= wdata_i;
						end
					end
				endcase
			end
			if (start) begin
				txe_q <= 1'b1;
			end
			if (wr_i && addr_i == ADDR_DATA) begin
				tx_buf_q <= wdata_i;
				txe_q <= 1'b0;
			end
			if (data_rd) begin
				rxf_q <= 1'b0;
			end
			if (last_edge) begin
				rxf_q <= 1'b1;
				if (rxf_q && !data_rd) begin
					ovr_q <= 1'b1;
				end else begin
					rx_buf_q <= cur_q[CMD_LSB_FIRST] ? rx_nx >> (5'd31 - len_m1) : rx_nx;
				end
			end
			if (start_s && txe_q) begin
				udr_q <= 1'b1;
			end
			if (master_en && ctl_q[CTL_MODE_FAULT_FLAG_EN] && sel_in_act) begin
				mode_fault_flag_q <= 1'b1;
				ctl_q[CTL_ENABLE] <= 1'b0;
			end
			if ((st_q == SM_NEXT && ctl_q[CTL_ENABLE] && pcnt_q == 3'h0 && bit_tick
			    && cnt_q == 4'h1 || !ctl_q[CTL_MASTER] && last_edge) && txe_q) begin
				cend_q <= 1'b1;
			end
		end
	end

	// ************************************************
	// read port, pins and requests
	// ************************************************
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= 32'h0000_0000;
			if (rd_i) begin
				unique case (addr_i)
					ADDR_CONTROL: rdata_q <= ctl_q;
					ADDR_STATUS: begin
						rdata_q[STS_RX_READY] <= rxf_q;
						rdata_q[STS_OVERRUN] <= ovr_q;
						rdata_q[STS_IDLE] <= st_q == SM_IDLE;
						rdata_q[STS_MODE_FAULT_FLAG] <= mode_fault_flag_q;
						rdata_q[STS_PARITY] <= 1'b0;
						rdata_q[STS_UNDERRUN] <= udr_q;
						rdata_q[STS_TXE] <= txe_q;
						rdata_q[STS_COMM_END] <= cend_q;
						rdata_q[STS_RXF] <= rxf_q;
					end
					ADDR_DATA_CONTROL: rdata_q[DCR_READBACK] <= readback_q;
					ADDR_POLARITY: rdata_q[3:0] <= pol_q;
					ADDR_NEGATE_DELAY: rdata_q[2:0] <= negd_q;
					ADDR_NEXT_DELAY: rdata_q[2:0] <= nextd_q;
					ADDR_CLOCK_DELAY: rdata_q[2:0] <= ckd_q;
					ADDR_SEQ_LAST: rdata_q[2:0] <= seq_last_q;
					ADDR_DATA: rdata_q <= readback_q ? tx_buf_q : rx_buf_q;
					default: begin
						if (addr_i[4] && addr_i[3:0] < 4'(NUM_CMDS)) begin
							rdata_q <= cmd_q[addr_i[2:0]];
						end
					end
				endcase
			end
		end
	end

	// miso is sampled through the synchroniser, so keep the half period at five clocks or more
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sel_q <= 4'hf;
			sel_oe_q <= 4'h0;
			sclk_oe_q <= 1'b0;
			mosi_q <= 1'b0;
			mosi_oe_q <= 1'b0;
			miso_q <= 1'b0;
			miso_oe_q <= 1'b0;
			irq_rx_q <= 1'b0;
			irq_tx_q <= 1'b0;
			irq_err_q <= 1'b0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (master_en && busy_sel && cur_q[CMD_SEL_LSB +: 3] == 3'(i)) begin
					sel_q[i] <= pol_q[i] ^ ssp;
				end else begin
					sel_q[i] <= ~(pol_q[i] ^ ssp);
				end
			end
			sel_oe_q <= master_en ? 4'hf : 4'h0;
			sclk_oe_q <= master_en;
			mosi_q <= out_bit;
			mosi_oe_q <= master_en;
			miso_q <= out_bit;
			miso_oe_q <= slave_en && (st_q == SM_SHIFT || st_q == SM_LAG);
			irq_rx_q <= rxf_q & ctl_q[CTL_RXF_IE];
			irq_tx_q <= txe_q & ctl_q[CTL_TXE_IE];
			irq_err_q <= (ovr_q | mode_fault_flag_q | udr_q) & ctl_q[CTL_ERR_IE];
		end
	end

	assign rdata_o = rdata_q;
	assign sclk_o = sclk_q;
	assign sclk_oe_o = sclk_oe_q;
	assign mosi_o = mosi_q;
	assign mosi_oe_o = mosi_oe_q;
	assign miso_o = miso_q;
	assign miso_oe_o = miso_oe_q;
	assign sel_o = sel_q;
	assign sel_oe_o = sel_oe_q;
	assign irq_rx_o = irq_rx_q;
	assign irq_tx_o = irq_tx_q;
	assign irq_err_o = irq_err_q;

	// ************************************************
	// checks
	// ************************************************
	AST_SLAVE_HIZ: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!ctl_q[CTL_MASTER] |=> sel_oe_o == 4'h0) else $error("select driven in slave mode");
	AST_NEXT_MIN: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		st_q == SM_LAG ##1 st_q == SM_NEXT |-> (st_q == SM_NEXT || !ctl_q[CTL_ENABLE])[*5])
		else $error("next-access delay too short");
	AST_TXE_CLR: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		wr_i && addr_i == ADDR_DATA |=> !txe_q) else $error("tx empty not cleared");
	AST_RXF_SET: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		last_edge |=> rxf_q) else $error("rx full not set at frame end");
	AST_OVR_SET: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		last_edge && rxf_q && !data_rd |=> ovr_q) else $error("overrun missed");
	AST_IRQ_RX: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!ctl_q[CTL_RXF_IE] ##1 !ctl_q[CTL_RXF_IE] |-> !irq_rx_o) else $error("masked rx request");
	AST_STATUS_RD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		rd_i && addr_i == ADDR_STATUS |=> rdata_o[STS_TXE] == $past(txe_q)
		&& rdata_o[STS_RXF] == $past(rxf_q)) else $error("status read mismatch");
	AST_MODE_FAULT_FLAG_OFF: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		master_en && ctl_q[CTL_MODE_FAULT_FLAG_EN] && sel_in_act && !wr_i |=> !ctl_q[CTL_ENABLE] && mode_fault_flag_q)
		else $error("mode fault did not disable");
	AST_SSP_LEAD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		st_q == SM_IDLE && start && ctl_q[CTL_MASTER] && ssp && !cmdw[CMD_CLKD_EN]
		|=> st_q == SM_SHIFT) else $error("frame protocol lead not zero");
endmodule
`default_nettype wire

// File: sim/spimsr_slave_model.sv
// partner model: serial peripheral answering the master in clock mode 0
`default_nettype none
module spimsr_slave_model (
	input wire logic sclk_i,
	input wire logic sel_i,
	input wire logic mosi_i,
	input wire logic [7:0] reply_i,
	output logic miso_o,
	output logic [7:0] got_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] shift_q = 8'h00;
	logic last_q = 1'b0;
	// ************************************************
	// eight-bit frames, as the commands are programmed
	// ************************************************
	always @(posedge sel_i) shift_q <= reply_i;
	always @(posedge sclk_i) if (sel_i) got_o <= {got_o[6:0], mosi_i};
	always @(negedge sclk_i) if (sel_i) shift_q <= {shift_q[6:0], 1'b0};
	always @(negedge sel_i) last_q <= shift_q[7];
	// a released line shows the inverse of its last bit, so a stale value never passes
	assign miso_o = sel_i ? shift_q[7] : ~last_q;
endmodule
`default_nettype wire

// File: sim/test_spimsr_core.sv
// testbench: registers, master frames, polarity, protocols, slave mode and faults
`default_nettype none
module test_spimsr_core import spimsr_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	// ************************************************
	// signals and expectations
	// ************************************************
	localparam logic [31:0] CMD_A = 32'h0207_0040;
	localparam logic [31:0] CMD_B = 32'h0107_e040;
	// bit time: two half periods of rate plus one clocks, rate 4
	// a shorter half period loses miso bits behind the input synchroniser
	localparam int BIT = 10;
	localparam logic [4:0] RA [6] = '{ADDR_CONTROL, ADDR_STATUS, ADDR_POLARITY,
		ADDR_CMD_BASE, ADDR_SEQ_LAST, 5'h09};
	localparam logic [31:0] RV [6] = '{CONTROL_RESET, 32'h0000_2200, 32'h0, CMD_RESET,
		32'h7, 32'h0};
	logic clock, rst_n, wr, rd, sclk_in, mosi_in, miso_in, sclk_q, first = 1'b0;
	logic sclk, sclk_oe, mosi, mosi_oe, miso, miso_oe, irq_rx, irq_tx, irq_err;
	logic [4:0] addr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] sel_in, sel, sel_oe, inact, act_q, pol;
	logic [7:0] reply, got;
	logic [7:0] seen [8];
	logic [3:0] line [8];
	int lead [8], tail [8], gap [8];
	int fail_count = 0, tests_run = 0, n_neg = 0, s_sel, s_edge, s_neg;
	wire logic [3:0] act = (sel ^ inact) & sel_oe;
	spimsr_core dut (.clock_i(clock), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sclk_i(sclk_in), .sclk_o(sclk),
		.sclk_oe_o(sclk_oe), .mosi_i(mosi_in), .mosi_o(mosi), .mosi_oe_o(mosi_oe),
		.miso_i(miso_in), .miso_o(miso), .miso_oe_o(miso_oe), .sel_i(sel_in), .sel_o(sel),
		.sel_oe_o(sel_oe), .irq_rx_o(irq_rx), .irq_tx_o(irq_tx), .irq_err_o(irq_err));
	spimsr_slave_model partner (.sclk_i(sclk), .sel_i(act != 4'h0), .mosi_i(mosi),
		.reply_i(reply), .miso_o(miso_in), .got_o(got));
	// ************************************************
	// tasks
	// ************************************************
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: seen %h, expected %h", $time, g, e);
		end
	endtask
	task automatic stop_test();
		if (fail_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic wreg(input logic [4:0] a, input logic [31:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rreg(input logic [4:0] a, output logic [31:0] v);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 v = rdata;
		@(posedge clock);
	endtask
	task automatic pause(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wait_neg(input int n);
		for (int i = 0; i < 4000 && n_neg < n; i++) @(posedge clock);
		check(32'(n_neg), 32'(n));
	endtask
	task automatic wait_txe();
		d = 32'h0;
		for (int i = 0; i < 400 && !d[STS_TXE]; i++) rreg(ADDR_STATUS, d);
	endtask
	// link clock of 64 ns, standing still outside the frame
	task automatic slave_frame(input logic [7:0] b);
		sel_in <= 4'he;
		#200;
		for (int i = 7; i >= 0; i--) begin
			mosi_in <= b[i];
			#32 sclk_in <= 1'b1;
			if (i == 3) check(32'(miso_oe), 32'h1);
			#32 sclk_in <= 1'b0;
		end
		#64 sel_in <= 4'hf;
		pause(8);
	endtask
	// ************************************************
	// frame monitor: select line, lead, tail and gap in clocks
	// ************************************************
	always @(posedge clock) begin
		sclk_q <= sclk;
		act_q <= act;
		s_sel <= s_sel + 1;
		s_edge <= s_edge + 1;
		s_neg <= s_neg + 1;
		if (act != 4'h0 && act_q == 4'h0) begin
			gap[n_neg] <= s_neg;
			line[n_neg] <= act;
			s_sel <= 1;
			first <= 1'b1;
		end
		if (sclk != sclk_q && act != 4'h0) begin
			if (first || act_q == 4'h0) lead[n_neg] <= (act_q == 4'h0) ? 0 : s_sel;
			first <= 1'b0;
			s_edge <= 1;
		end
		if (act == 4'h0 && act_q != 4'h0) begin
			tail[n_neg] <= s_edge;
			seen[n_neg] <= got;
			n_neg <= n_neg + 1;
			s_neg <= 1;
		end
	end
	// ************************************************
	// clock, watchdog and test sequence
	// ************************************************
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// the run needs about 4 us; twenty-five times that means a hang
	initial begin
		#100000;
		fail_count++;
		stop_test();
	end
	initial begin
		{rst_n, wr, rd, sclk_in, mosi_in} = 5'h00;
		addr = 5'h00;
		wdata = 32'h0;
		sel_in = 4'hf;
		inact = 4'hf;
		reply = 8'hc3;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		for (int i = 0; i < 6; i++) begin
			rreg(RA[i], d);
			check(d, RV[i]);
		end
		wreg(ADDR_CONTROL, 32'h0113_4000);
		rreg(ADDR_CONTROL, d);
		check(d, 32'h0113_4000);
		check(32'(irq_tx), 32'h1);
		wreg(ADDR_CONTROL, 32'h0);
		pause(2);
		check(32'(irq_tx), 32'h0);
		for (int i = 0; i < 4; i++) begin
			pol = i[0] ? 4'h5 : 4'h0;
			wreg(ADDR_POLARITY, {28'h0, pol});
			wreg(ADDR_CONTROL, {7'h0, i[1], 24'h0});
			pause(2);
			check({28'h0, sel}, {28'h0, ~(pol ^ {4{i[1]}})});
		end
		// settings change only while the unit is disabled
		wreg(ADDR_POLARITY, 32'h0);
		wreg(ADDR_CONTROL, 32'h0);
		inact = 4'hf;
		wreg(ADDR_CMD_BASE, CMD_A);
		wreg(ADDR_CMD_BASE + 5'h1, CMD_B);
		rreg(ADDR_CMD_BASE + 5'h1, d);
		check(d, CMD_B);
		wreg(ADDR_CLOCK_DELAY, 32'h3);
		wreg(ADDR_NEGATE_DELAY, 32'h3);
		wreg(ADDR_NEXT_DELAY, 32'h2);
		wreg(ADDR_SEQ_LAST, 32'h1);
		wreg(ADDR_CONTROL, 32'h4003_0001);
		// next word is queued early so the gaps show only the delays
		wreg(ADDR_DATA, 32'h0000_00a5);
		wait_txe();
		wreg(ADDR_DATA, 32'h0000_003c);
		wait_neg(1);
		reply = 8'h69;
		wait_txe();
		wreg(ADDR_DATA, 32'h0000_005a);
		wait_neg(3);
		check({seen[0], seen[1], seen[2], 8'h0}, 32'ha53c_5a00);
		check({20'h0, line[0], line[1], line[2]}, 32'h0000_0424);
		check(32'(lead[1] - lead[0]), 32'(3 * BIT));
		check(32'(tail[1] - tail[0]), 32'(3 * BIT));
		check(32'(gap[2] - gap[1]), 32'(2 * BIT));
		// comm end rises only once the last next-access delay has run out
		pause(40);
		rreg(ADDR_STATUS, d);
		check(d & 32'hc101, 32'hc101);
		check({29'h0, irq_rx, irq_err, irq_tx}, 32'h6);
		rreg(ADDR_DATA, d);
		check(d, 32'h0000_00c3);
		wreg(ADDR_DATA_CONTROL, 32'h8);
		rreg(ADDR_DATA, d);
		check(d, 32'h0000_005a);
		wreg(ADDR_DATA_CONTROL, 32'h0);
		wreg(ADDR_STATUS, 32'h0);
		rreg(ADDR_STATUS, d);
		check(d & 32'h5d00, 32'h0);
		check(32'(irq_err), 32'h0);
		// frame protocol: active-high select, no lead bit
		wreg(ADDR_CONTROL, 32'h0);
		wreg(ADDR_CMD_BASE + 5'h1, CMD_A);
		inact = 4'h0;
		wreg(ADDR_CONTROL, 32'h4103_0001);
		wreg(ADDR_DATA, 32'h0000_0011);
		wait_neg(4);
		check({28'h0, line[3]}, 32'h4);
		check(32'(lead[0] - lead[3]), 32'(BIT));
		// slave mode: select 0 is an input, select, clock and mosi undriven, miso driven in the frame, tx empty gives underrun
		wreg(ADDR_CONTROL, 32'h0);
		inact = 4'hf;
		wreg(ADDR_CONTROL, 32'h0000_0001);
		pause(2);
		check({26'h0, sel_oe, sclk_oe, mosi_oe}, 32'h0);
		slave_frame(8'h9b);
		rreg(ADDR_STATUS, d);
		check(d & 32'h9000, 32'h9000);
		// mode fault: master sees its select input driven active
		wreg(ADDR_CONTROL, 32'h0);
		wreg(ADDR_CONTROL, 32'h4000_4001);
		sel_in <= 4'he;
		pause(8);
		rreg(ADDR_STATUS, d);
		check(d & 32'h0400, 32'h0400);
		rreg(ADDR_CONTROL, d);
		check(d & 32'h1, 32'h0);
		stop_test();
	end
endmodule
`default_nettype wire
